/* mmd_pkg.sv */
// Constants, types and decode functions for the memory map decoder
package mmd_pkg;
   localparam int          NUM_LINKS   = 4;
   localparam int          DATA_W      = 32;
   localparam int          SRAM_AW     = 16;
   localparam int          BLOCK_BITS  = 18;
   localparam logic [17:0] INT_LIMIT   = 18'h01000;
   localparam logic [17:0] EXT_LIMIT   = 18'h28000;
   localparam logic [31:0] BLOCK_SPAN  = 32'h00040000;
   localparam logic [31:0] EXT_FIRST   = 32'h80001000;
   localparam logic [31:0] EXT_LAST    = 32'h80027fff;
   localparam logic [15:0] SRAM_WORDS  = 16'h9c00;
   localparam int          CLK_MHZ     = 40;
   localparam int          CLK_NS      = 25;
   localparam int          ACCESS_NS   = 100;
   localparam int          ACCESS_CYC  = ACCESS_NS / CLK_NS;
   localparam logic [2:0]  ACC_LAST    = 3'(ACCESS_CYC - 1);
   localparam int          SLOW_MBPS   = 10;
   localparam int          FAST_MBPS   = 20;
   localparam logic [1:0]  SLOW_LAST   = 2'(CLK_MHZ / SLOW_MBPS - 1);
   localparam logic [1:0]  FAST_LAST   = 2'(CLK_MHZ / FAST_MBPS - 1);

   typedef enum logic [1:0] {MMD_INT, MMD_EXT, MMD_GAP} mmd_region_type;

   function automatic mmd_region_type mmd_region(input logic [31:0] addr);
      logic [17:0] off;
      off = addr[BLOCK_BITS-1:0];
      if (off < INT_LIMIT) begin
         return MMD_INT;
      end else if (off < EXT_LIMIT) begin
         return MMD_EXT;
      end
      return MMD_GAP;
   endfunction

   function automatic logic [15:0] mmd_sram_index(input logic [31:0] addr);
      logic [17:0] rel;
      rel = addr[BLOCK_BITS-1:0] - INT_LIMIT;
      return rel[17:2];
   endfunction
endpackage

/* mmd_ifs.sv */
// Interfaces between the decoder top, address decode and link rate logic
`timescale 1ns/100ps
interface mmd_dec_if;
   import mmd_pkg::*;
   logic [31:0]    addr;
   mmd_region_type region;
   logic [15:0]    index;
   modport dec (input addr, output region, output index);
   modport use_side (output addr, input region, input index);
endinterface

interface mmd_link_if;
   logic [3:0] fast;
   logic [3:0] tick;
   logic [3:0] rx;
   logic [3:0] idle;
   modport gen (output fast, output tick, output rx, output idle);
   modport use_side (input fast, input tick, input rx, input idle);
endinterface

/* mmd_addr_decode.sv */
// Address decode into internal, external and gap regions
`timescale 1ns/100ps
module mmd_addr_decode
   import mmd_pkg::*;
(
   input wire logic clk,   // System clock
   input wire logic rst_n, // Sync reset, active low
   mmd_dec_if.dec   dec    // Address in, region out
);
   assign dec.region = mmd_region(dec.addr);
   assign dec.index  = mmd_sram_index(dec.addr);

   int_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dec.addr[17:0] < INT_LIMIT) |-> dec.region == MMD_INT)
      else $error("low 4K not internal");
   ext_window_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dec.addr >= EXT_FIRST && dec.addr <= EXT_LAST) |-> dec.region == MMD_EXT)
      else $error("external window misdecoded");
   ext_index_a: assert property (@(posedge clk) disable iff (!rst_n)
      dec.region == MMD_EXT |-> dec.index < SRAM_WORDS)
      else $error("sram index beyond 156K");
   gap_region_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dec.addr[17:0] >= EXT_LIMIT) |-> dec.region == MMD_GAP)
      else $error("gap not empty");
   block_alias_a: assert property (@(posedge clk) disable iff (!rst_n)
      dec.region == mmd_region(dec.addr + BLOCK_SPAN)
      && dec.index == mmd_sram_index(dec.addr + BLOCK_SPAN))
      else $error("256K blocks do not alias");
endmodule

/* mmd_link_rate.sv */
// Link rate straps, bit rate enables and link input synchronisers
`timescale 1ns/100ps
module mmd_link_rate
   import mmd_pkg::*;
(
   input wire logic       clk,                 // System clock
   input wire logic       rst_n,               // Sync reset, active low
   input wire logic       link0_rate_strap,    // Strap pin, link 0
   input wire logic       links123_rate_strap, // Strap pin, links 1-3
   input wire logic [3:0] serial_rx_lines,     // Raw link inputs
   mmd_link_if.gen        lnk                  // Rates, enables, inputs
);
   logic [1:0] strap_s1_q;
   logic [1:0] strap_s2_q;
   logic [3:0] rx_s1_q;
   logic [3:0] rx_s2_q;
   logic [3:0] fast_q;
   logic [1:0] slow_cnt_q;
   logic [1:0] fast_cnt_q;
   logic [3:0] tick_q;

   always_ff @(posedge clk) begin
      strap_s1_q <= {links123_rate_strap, link0_rate_strap};
      strap_s2_q <= strap_s1_q;
      rx_s1_q    <= serial_rx_lines;
      rx_s2_q    <= rx_s1_q;
   end

   // Straps are followed while reset is held, then frozen
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fast_q <= {{3{strap_s2_q[1]}}, strap_s2_q[0]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         slow_cnt_q <= 2'h0;
         fast_cnt_q <= 2'h0;
         tick_q     <= 4'h0;
      end else begin
         slow_cnt_q <= (slow_cnt_q == SLOW_LAST) ? 2'h0 : slow_cnt_q + 2'h1;
         fast_cnt_q <= (fast_cnt_q == FAST_LAST) ? 2'h0 : fast_cnt_q + 2'h1;
         for (int i = 0; i < NUM_LINKS; i++) begin
            tick_q[i] <= fast_q[i] ? (fast_cnt_q == FAST_LAST)
                                   : (slow_cnt_q == SLOW_LAST);
         end
      end
   end

   assign lnk.fast = fast_q;
   assign lnk.tick = tick_q;
   assign lnk.rx   = rx_s2_q;
   assign lnk.idle = ~rx_s2_q;

   slow_period_a: assert property (@(posedge clk) disable iff (!rst_n)
      (tick_q[0] && !fast_q[0]) |=> !tick_q[0] [*3] ##1 tick_q[0])
      else $error("10 Mbit/s enable period wrong");
   fast_period_a: assert property (@(posedge clk) disable iff (!rst_n)
      (tick_q[1] && fast_q[1]) |=> !tick_q[1] ##1 tick_q[1])
      else $error("20 Mbit/s enable period wrong");
   low_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(serial_rx_lines, 2) == 4'h0 |-> lnk.idle == 4'hf)
      else $error("low link input not idle");
endmodule

/* mmd_top.sv */
// Memory map decoder with zero-wait external SRAM access and link pins
// Overview of operation
// - Lowest 4 Kbytes of each block go to processor internal RAM.
// - 156 Kbytes external SRAM sits directly above internal RAM.
// - A 96 Kbyte unpopulated region follows the external SRAM.
// - The 160K populated plus gap pattern repeats every 256 Kbytes.
// - External SRAM answers from 80001000 to 80027fff inclusive.
// - Each external access takes 100 ns with no wait states.
// - Strap one sets link 0, strap two links 1-3; high means 20 Mbit/s.
// - Fault pin pulled low during error, released otherwise for wire-OR.
// - A low, unconnected link input counts as idle on link_idle; its bit rate enable keeps running.
// - Four independent links, each one input and one output line.
`timescale 1ns/100ps
module mmd_top
   import mmd_pkg::*;
(
   input  wire logic              clk,                     // 40 MHz clock
   input  wire logic              rst_n,                   // Sync reset, active low
   input  wire logic              cpu_req,                 // Access request pulse
   input  wire logic              cpu_we,                  // Write when high
   input  wire logic [3:0]        cpu_be,                  // Byte enables
   input  wire logic [31:0]       cpu_addr,                // Byte address
   input  wire logic [DATA_W-1:0] cpu_wdata,               // Write data
   output logic      [DATA_W-1:0] cpu_rdata,               // Read data
   output logic                   cpu_ack,                 // Access done pulse
   output logic                   cpu_busy,                // Access in progress
   output logic                   int_ram_sel,             // Internal RAM claimed
   output logic      [SRAM_AW-1:0] sram_addr,              // SRAM word address
   output logic                   sram_ce_n,               // SRAM chip enable
   output logic                   sram_oe_n,               // SRAM output enable
   output logic                   sram_we_n,               // SRAM write enable
   output logic      [3:0]        sram_be_n,               // SRAM byte enables
   input  wire logic [DATA_W-1:0] sram_dq_in,              // SRAM data in
   output logic      [DATA_W-1:0] sram_dq_out,             // SRAM data out
   output logic                   sram_dq_oe,              // SRAM data drive
   input  wire logic              link0_rate_strap,        // Link 0 rate strap
   input  wire logic              links123_rate_strap,     // Links 1-3 rate strap
   input  wire logic [3:0]        serial_rx_lines,         // Link input pins
   output logic      [3:0]        serial_tx_lines,         // Link output pins
   input  wire logic [3:0]        link_tx_bits,            // Link engine output
   output logic      [3:0]        link_rx_bits,            // Synced link inputs
   output logic      [3:0]        link_idle,               // Link input idle
   output logic      [3:0]        link_fast,               // Link at 20 Mbit/s
   output logic      [3:0]        link_tick,               // Bit rate enables
   input  wire logic              cpu_error,               // Processor error
   input  wire logic              fault_indicator_low_in,  // Fault wire level
   output logic                   fault_indicator_low_out, // Fault pin value
   output logic                   fault_indicator_low_oe,  // Fault pin drive
   output logic                   fault_bus_low            // Shared fault seen
);
   typedef enum logic {MMD_IDLE, MMD_ACCESS} mmd_state_type;

   mmd_dec_if  dec ();
   mmd_link_if lnk ();

   mmd_state_type state_q;
   logic [2:0]    cnt_q;
   logic          ext_q;
   logic          take;
   logic          ack_q;
   logic [DATA_W-1:0] rdata_q;
   logic [SRAM_AW-1:0] sram_addr_q;
   logic          ce_n_q;
   logic          oe_n_q;
   logic          we_n_q;
   logic [3:0]    be_n_q;
   logic [DATA_W-1:0] dq_out_q;
   logic          dq_oe_q;
   logic [3:0]    tx_q;
   logic          fault_oe_q;
   logic          fault_s1_q;
   logic          fault_s2_q;

   mmd_addr_decode u_decode (
      .clk   (clk),
      .rst_n (rst_n),
      .dec   (dec)
   );

   mmd_link_rate u_links (
      .clk                 (clk),
      .rst_n               (rst_n),
      .link0_rate_strap    (link0_rate_strap),
      .links123_rate_strap (links123_rate_strap),
      .serial_rx_lines     (serial_rx_lines),
      .lnk                 (lnk)
   );

   assign dec.addr = cpu_addr;

   // Internal RAM is served by the processor itself, no SRAM cycle
   assign take        = cpu_req && state_q == MMD_IDLE && dec.region != MMD_INT;
   assign int_ram_sel = cpu_req && state_q == MMD_IDLE && dec.region == MMD_INT;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= MMD_IDLE;
         cnt_q   <= 3'h0;
         ext_q   <= 1'b0;
         ack_q   <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         case (state_q)
            MMD_IDLE: begin
               if (take) begin
                  state_q <= MMD_ACCESS;
                  cnt_q   <= 3'h0;
                  ext_q   <= dec.region == MMD_EXT;
               end
            end
            MMD_ACCESS: begin
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == ACC_LAST) begin
                  state_q <= MMD_IDLE;
                  ack_q   <= 1'b1;
               end
            end
            default: begin
               state_q <= MMD_IDLE;
            end
         endcase
      end
   end

   // SRAM strobes held for the whole access, no wait states
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sram_addr_q <= 16'h0000;
         ce_n_q      <= 1'b1;
         oe_n_q      <= 1'b1;
         we_n_q      <= 1'b1;
         be_n_q      <= 4'hf;
         dq_out_q    <= 32'h0000_0000;
         dq_oe_q     <= 1'b0;
      end else if (take && dec.region == MMD_EXT) begin
         sram_addr_q <= dec.index;
         ce_n_q      <= 1'b0;
         oe_n_q      <= cpu_we;
         we_n_q      <= !cpu_we;
         be_n_q      <= ~cpu_be;
         dq_out_q    <= cpu_wdata;
         dq_oe_q     <= cpu_we;
      end else if (state_q == MMD_ACCESS && cnt_q == ACC_LAST) begin
         ce_n_q  <= 1'b1;
         oe_n_q  <= 1'b1;
         we_n_q  <= 1'b1;
         be_n_q  <= 4'hf;
         dq_oe_q <= 1'b0;
      end
   end

   // Gap reads return zero; the value is not promised
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (state_q == MMD_ACCESS && cnt_q == ACC_LAST) begin
         rdata_q <= (ext_q && oe_n_q == 1'b0) ? sram_dq_in : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_q <= 4'h0;
      end else begin
         tx_q <= link_tx_bits;
      end
   end

   // Open drain: only ever pull low, never drive high
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_oe_q <= 1'b0;
      end else begin
         fault_oe_q <= cpu_error;
      end
   end

   always_ff @(posedge clk) begin
      fault_s1_q <= fault_indicator_low_in;
      fault_s2_q <= fault_s1_q;
   end

   assign cpu_rdata               = rdata_q;
   assign cpu_ack                 = ack_q;
   assign cpu_busy                = state_q == MMD_ACCESS;
   assign sram_addr               = sram_addr_q;
   assign sram_ce_n               = ce_n_q;
   assign sram_oe_n               = oe_n_q;
   assign sram_we_n               = we_n_q;
   assign sram_be_n               = be_n_q;
   assign sram_dq_out             = dq_out_q;
   assign sram_dq_oe              = dq_oe_q;
   assign serial_tx_lines         = tx_q;
   assign link_rx_bits            = lnk.rx;
   assign link_idle               = lnk.idle;
   assign link_fast               = lnk.fast;
   assign link_tick               = lnk.tick;
   assign fault_indicator_low_out = 1'b0;
   assign fault_indicator_low_oe  = fault_oe_q;
   assign fault_bus_low           = !fault_s2_q;

   ext_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
      (take && dec.region == MMD_EXT)
      |=> (!sram_ce_n && !cpu_ack) [*4] ##1 (sram_ce_n && cpu_ack))
      else $error("external access not 100 ns");
   ext_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      (take && dec.region == MMD_EXT)
      |=> sram_addr == 16'($past(cpu_addr[17:0]) - 18'h01000 >> 2))
      else $error("sram address not offset by 4K");
   gap_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      (take && dec.region == MMD_GAP)
      |=> (sram_ce_n && sram_we_n) [*4] ##1 cpu_ack)
      else $error("gap access touched SRAM");
   int_no_sram_a: assert property (@(posedge clk) disable iff (!rst_n)
      int_ram_sel |=> sram_ce_n && !cpu_busy)
      else $error("internal access started SRAM");
   fault_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
      cpu_error |=> fault_indicator_low_oe && !fault_indicator_low_out)
      else $error("fault pin not pulled low");
   fault_release_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cpu_error |=> !fault_indicator_low_oe)
      else $error("fault pin not released");
   tx_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> serial_tx_lines == $past(link_tx_bits))
      else $error("link outputs not independent");

   // Access sequencing
   ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      cpu_ack |=> !cpu_ack)
      else $error("ack longer than one cycle");
   ack_end_a: assert property (@(posedge clk) disable iff (!rst_n)
      cpu_ack |-> !cpu_busy && $past(cpu_busy))
      else $error("ack not at end of access");
   idle_no_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!cpu_busy && !$past(cpu_busy)) |-> !cpu_ack)
      else $error("ack without access");
   busy_length_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(cpu_busy) |-> cpu_busy [*4] ##1 (!cpu_busy && cpu_ack))
      else $error("access length not four cycles");
   cnt_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(cpu_busy) |-> cnt_q == 3'h0)
      else $error("access counter not cleared");
   cnt_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cpu_busy && $past(cpu_busy)) |-> cnt_q == $past(cnt_q) + 3'h1)
      else $error("access counter skipped");
   cnt_range_a: assert property (@(posedge clk) disable iff (!rst_n)
      cpu_busy |-> cnt_q <= ACC_LAST)
      else $error("access counter overran");

   // SRAM strobes
   ce_in_access_a: assert property (@(posedge clk) disable iff (!rst_n)
      !sram_ce_n |-> cpu_busy)
      else $error("chip enable outside access");
   idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cpu_busy |-> sram_ce_n && sram_oe_n && sram_we_n
                    && sram_be_n == 4'hf && !sram_dq_oe)
      else $error("strobes active while idle");
   strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(!sram_oe_n && !sram_we_n))
      else $error("read and write strobes together");
   drive_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      sram_dq_oe |-> !sram_we_n && !sram_ce_n)
      else $error("data driven outside write");
   strobe_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!sram_ce_n && !$past(sram_ce_n)) |-> $stable(sram_addr) && $stable(sram_be_n)
                                           && $stable(sram_we_n) && $stable(sram_dq_out))
      else $error("strobes moved inside access");
   write_setup_a: assert property (@(posedge clk) disable iff (!rst_n)
      (take && dec.region == MMD_EXT && cpu_we)
      |=> !sram_we_n && sram_oe_n && sram_dq_oe && sram_dq_out == $past(cpu_wdata))
      else $error("write not set up");
   read_setup_a: assert property (@(posedge clk) disable iff (!rst_n)
      (take && dec.region == MMD_EXT && !cpu_we)
      |=> !sram_oe_n && sram_we_n && !sram_dq_oe && sram_be_n == ~$past(cpu_be))
      else $error("read not set up");

   // Read data
   read_data_a: assert property (@(posedge clk) disable iff (!rst_n)
      (take && dec.region == MMD_EXT && !cpu_we) |-> ##5 cpu_rdata == $past(sram_dq_in))
      else $error("read data not from sram");
   gap_data_a: assert property (@(posedge clk) disable iff (!rst_n)
      (take && dec.region == MMD_GAP) |-> ##5 cpu_rdata == 32'h0000_0000)
      else $error("gap read not zero");
   rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cpu_ack |-> $stable(cpu_rdata))
      else $error("read data moved without ack");
   int_no_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
      int_ram_sel |=> !cpu_ack)
      else $error("internal access acked");

   // Link rates
   tick_single_a: assert property (@(posedge clk) disable iff (!rst_n)
      (link_tick & $past(link_tick)) == 4'h0)
      else $error("bit enable longer than one cycle");
   tick_shared_a: assert property (@(posedge clk) disable iff (!rst_n)
      link_tick[3:1] == {3{link_tick[1]}} && link_fast[3:1] == {3{link_fast[1]}})
      else $error("links 1-3 rate differs");
   slow_group_a: assert property (@(posedge clk) disable iff (!rst_n)
      (link_tick[1] && !link_fast[1]) |=> !link_tick[1] [*3] ##1 link_tick[1])
      else $error("links 1-3 slow period wrong");
   fast_link0_a: assert property (@(posedge clk) disable iff (!rst_n)
      (link_tick[0] && link_fast[0]) |=> !link_tick[0] ##1 link_tick[0])
      else $error("link 0 fast period wrong");
endmodule

/* mmd_sram_model.sv */
// Behavioural external SRAM on the far side of the decoder
`timescale 1ns/100ps
module mmd_sram_model
   import mmd_pkg::*;
(
   input  wire logic [0:0]         clk,  // System clock
   input  wire logic [SRAM_AW-1:0] addr, // Word address
   input  wire logic               ce_n, // Chip enable
   input  wire logic               oe_n, // Output enable
   input  wire logic               we_n, // Write enable
   input  wire logic [3:0]         be_n, // Byte enables
   input  wire logic [DATA_W-1:0]  din,  // Write data
   output logic      [DATA_W-1:0]  dout  // Read data
);
   logic [DATA_W-1:0] mem [int'(SRAM_WORDS)];
   logic [DATA_W-1:0] last_q = '0;

   // Byte lane writes into the 156 Kbyte array
   always @(posedge clk) begin
      if (!ce_n && !we_n) begin
         for (int b = 0; b < 4; b++) begin
            if (!be_n[b]) begin
               mem[addr][8*b +: 8] <= din[8*b +: 8];
            end
         end
      end
      if (!ce_n && !oe_n) begin
         last_q <= dout;
      end
   end

   // Zero-wait read; a released bus shows the inverse of the last value
   assign dout = (!ce_n && !oe_n) ? mem[addr] : ~last_q;
endmodule

/* module_memory_map_decode_tb_top.sv */
// Self-checking testbench for the memory map decoder
`timescale 1ns/100ps
module module_memory_map_decode_tb_top;
   import mmd_pkg::*;
   typedef struct packed {
      logic [31:0] addr;
      logic        we;
      logic [3:0]  be;
      logic [31:0] wdata;
      logic [31:0] rdata;
   } mmd_row_type;

   logic              clk = 1'b0, rst_n = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0;
   logic [3:0]        cpu_be = 4'h0, serial_rx_lines = 4'h0, link_tx_bits = 4'h0;
   logic [31:0]       cpu_addr = 32'h0, cpu_wdata = 32'h0;
   logic              link0_rate_strap = 1'b0, links123_rate_strap = 1'b0, cpu_error = 1'b0;
   logic [DATA_W-1:0] cpu_rdata, sram_dq_in, sram_dq_out;
   logic [15:0]       sram_addr;
   logic [3:0]        sram_be_n, serial_tx_lines, link_rx_bits, link_idle, link_fast, link_tick;
   logic              cpu_ack, cpu_busy, int_ram_sel, sram_ce_n, sram_oe_n, sram_we_n;
   logic              sram_dq_oe, fault_indicator_low_out, fault_indicator_low_oe, fault_bus_low;
   wire logic         fault_indicator_low_in;
   int                miscompares = 0;
   int                comparisons = 0;
   mmd_row_type       rows [10] = '{
      '{32'h80001000, 1'b1, 4'hf, 32'h11223344, 32'h0},
      '{32'h80027ffc, 1'b1, 4'hf, 32'ha5a55a5a, 32'h0},
      '{32'h80001000, 1'b0, 4'hf, 32'h0, 32'h11223344},
      '{32'h80027ffc, 1'b0, 4'hf, 32'h0, 32'ha5a55a5a},
      '{32'h00041000, 1'b1, 4'h3, 32'h0000beef, 32'h0},
      '{32'h80001000, 1'b0, 4'hf, 32'h0, 32'h1122beef},
      '{32'h80028000, 1'b1, 4'hf, 32'hffffffff, 32'h0},
      '{32'h8003fffc, 1'b0, 4'hf, 32'h0, 32'h0},
      '{32'h80027ffc, 1'b0, 4'hf, 32'h0, 32'ha5a55a5a},
      '{32'h00001000, 1'b0, 4'hf, 32'h0, 32'h1122beef}};

   // Open-drain fault wire with its motherboard pull-up
   assign fault_indicator_low_in = fault_indicator_low_oe ? fault_indicator_low_out : 1'b1;

   mmd_top i_dut (.clk, .rst_n, .cpu_req, .cpu_we, .cpu_be, .cpu_addr, .cpu_wdata, .cpu_rdata,
      .cpu_ack, .cpu_busy, .int_ram_sel, .sram_addr, .sram_ce_n, .sram_oe_n, .sram_we_n,
      .sram_be_n, .sram_dq_in, .sram_dq_out, .sram_dq_oe, .link0_rate_strap,
      .links123_rate_strap, .serial_rx_lines, .serial_tx_lines, .link_tx_bits, .link_rx_bits,
      .link_idle, .link_fast, .link_tick, .cpu_error, .fault_indicator_low_in,
      .fault_indicator_low_out, .fault_indicator_low_oe, .fault_bus_low);

   mmd_sram_model i_sram (.clk(clk), .addr(sram_addr), .ce_n(sram_ce_n), .oe_n(sram_oe_n),
      .we_n(sram_we_n), .be_n(sram_be_n), .din(sram_dq_out), .dout(sram_dq_in));

   always #12.5 clk = ~clk;

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Entered at a falling edge; straps are captured while reset is held
   task automatic do_reset(input logic a, input logic b);
      rst_n = 1'b0;
      link0_rate_strap = a;
      links123_rate_strap = b;
      repeat (3) @(negedge clk);
      check_val({cpu_busy, cpu_ack, sram_ce_n, fault_indicator_low_oe}, 4'h2);
      check_val(link_fast, {{3{b}}, a});
      rst_n = 1'b1;
   endtask

   task automatic access(input mmd_row_type r);
      logic gap;
      int   n;
      gap = r.addr[17:0] >= 18'h28000;
      cpu_req = 1'b1;
      cpu_we = r.we;
      cpu_be = r.be;
      cpu_addr = r.addr;
      cpu_wdata = r.wdata;
      @(negedge clk);
      cpu_req = 1'b0;
      check_val({sram_ce_n, sram_we_n, sram_oe_n}, {gap, gap | !r.we, gap | r.we});
      if (!gap) begin
         check_val(16'((r.addr[17:0] - 18'h1000) >> 2), sram_addr);
         check_val({sram_be_n, sram_dq_oe}, {~r.be, r.we});
      end
      n = 1;
      while (cpu_ack !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
         if (n == 4) begin
            check_val(sram_ce_n, gap);
         end
      end
      check_val(n, 5);
      check_val(cpu_busy, 1'b0);
      if (!r.we) begin
         check_val(cpu_rdata, r.rdata);
      end
   endtask

   task automatic tick_gap(input int l, input logic fast);
      int n;
      n = 0;
      while (link_tick[l] !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (link_tick[l] !== 1'b1 && n < 10);
      // Four clocks per bit at 10 Mbit/s, two at 20 Mbit/s
      check_val(n, fast ? 2 : 4);
   endtask

   initial begin
      #(25 * 20000);
      miscompares++;
      finish_test();
   end

   initial begin
      do_reset(1'b0, 1'b0);
      // Back to back: each row is raised in the ack cycle of the last
      foreach (rows[i]) begin
         access(rows[i]);
      end
      cpu_addr = 32'h80000ffc;
      cpu_req = 1'b1;
      #1 check_val(int_ram_sel, 1'b1);
      for (int k = 0; k < 7; k++) begin
         @(negedge clk);
         cpu_req = 1'b0;
         check_val({cpu_ack, sram_ce_n, cpu_busy}, 3'b010);
      end
      link_tx_bits = 4'ha;
      serial_rx_lines = 4'h5;
      @(negedge clk);
      check_val(serial_tx_lines, 4'ha);
      @(negedge clk);
      check_val({link_rx_bits, link_idle}, 8'h5a);
      serial_rx_lines = 4'h0;
      link_tx_bits = 4'h5;
      cpu_error = 1'b1;
      @(negedge clk);
      check_val({serial_tx_lines, fault_indicator_low_oe, fault_indicator_low_in}, 6'h16);
      @(negedge clk);
      check_val({link_idle, link_rx_bits}, 8'hf0);
      @(negedge clk);
      check_val(fault_bus_low, 1'b1);
      cpu_error = 1'b0;
      repeat (4) @(negedge clk);
      check_val({fault_indicator_low_oe, fault_indicator_low_in, fault_bus_low}, 3'b010);
      for (int i = 0; i < 4; i++) begin
         do_reset(i[0], i[1]);
         tick_gap(0, i[0]);
         tick_gap(1, i[1]);
         tick_gap(3, i[1]);
      end
      finish_test();
   end
endmodule
